// *** src/sdc_pkg.sv ***
// Purpose: Shared constants for the synthesizer configuration link and its controller.
// Assumes: One 50 MHz clock named mclk on both ends.
// Notes: Serial frame is test bits, post-divider bits, then feedback-divider bits.
package sdc_pkg;
	localparam int M_W = 9;
	localparam int N_W = 2;
	localparam int T_W = 3;
	localparam int FRAME_W = 14;
	localparam int M_LSB = 0;
	localparam int N_LSB = 9;
	localparam int T_LSB = 11;
	localparam logic [M_W-1:0] M_RESET = 9'h000;
	localparam logic [N_W-1:0] N_RESET = 2'h0;
	localparam logic [T_W-1:0] T_RESET = 3'h0;
	localparam logic [FRAME_W-1:0] SHIFT_RESET = 14'h0000;
	localparam int REF_DIV_W = 4;
	localparam logic [T_W-1:0] TEST_SHIFT = 3'h0;
	localparam logic [T_W-1:0] TEST_ONE = 3'h1;
	localparam logic [T_W-1:0] TEST_REF = 3'h2;
	localparam logic [T_W-1:0] TEST_FB = 3'h3;
	localparam logic [T_W-1:0] TEST_SYNTH = 3'h4;
	localparam logic [T_W-1:0] TEST_ZERO = 3'h5;
	localparam logic [T_W-1:0] TEST_BYPASS = 3'h6;
	localparam logic [T_W-1:0] TEST_SYNTH4 = 3'h7;
	localparam int CLK_PERIOD_NS = 20;
	localparam int SER_HALF_NS = 50;
	localparam int LOAD_PULSE_NS = 50;
	localparam int SETUP_NS = 20;
	localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOAD_PULSE_CYC = (LOAD_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam int CMD_PAR_BIT = 0;
	localparam int CMD_SER_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;

	// Post-divider code to divide ratio.
	function automatic logic [3:0] post_ratio(input logic [N_W-1:0] code);
		post_ratio = 4'h1 << code;
	endfunction
endpackage

// *** src/sdc_link_if.sv ***
// Purpose: Pin-level link between the board controller and the synthesizer configuration logic.
// Assumes: Both ends run on the same mclk; the device resynchronises every pin it reads.
// Notes: synth_pair bit 1 is the true output and bit 0 its complement.
`timescale 1ns/1ps
interface sdc_link_if;
	import sdc_pkg::*;
	logic [M_W-1:0] par_m;
	logic [N_W-1:0] par_n;
	logic par_load;
	logic ser_clk;
	logic ser_data;
	logic ser_load;
	logic test_out;
	logic [1:0] synth_output_pair;

	modport dev (
		input par_m,
		input par_n,
		input par_load,
		input ser_clk,
		input ser_data,
		input ser_load,
		output test_out,
		output synth_output_pair
	);

	modport ctl (
		output par_m,
		output par_n,
		output par_load,
		output ser_clk,
		output ser_data,
		output ser_load,
		input test_out,
		input synth_output_pair
	);
endinterface

// *** src/sdc_synth_dev.sv ***
// Purpose: Divider configuration, serial port and test multiplexer of the clock synthesizer.
// Assumes: vco_tick marks each VCO half period; xtal_tick marks each crystal period.
// Notes: Link pins pass three flops; a change counts once stages two and three agree.
`timescale 1ns/1ps
module sdc_synth_dev
	import sdc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	sdc_link_if.dev link,
	input wire logic vco_tick,
	input wire logic xtal_tick,
	output logic [M_W-1:0] cfg_m,
	output logic [N_W-1:0] cfg_n,
	output logic [T_W-1:0] cfg_t
);
	localparam int IN_W = 4 + M_W + N_W;
	localparam int PL = IN_W - 1;
	localparam int SC = IN_W - 2;
	localparam int SD = IN_W - 3;
	localparam int SL = IN_W - 4;

	logic [IN_W-1:0] raw;
	logic [IN_W-1:0] s1_r, s2_r, s3_r, filt_r, prev_r;
	logic [IN_W-1:0] filt_nxt;
	logic [M_W-1:0] m_r, m_nxt;
	logic [N_W-1:0] n_r, n_nxt;
	logic [T_W-1:0] t_r, t_nxt;
	logic [FRAME_W-1:0] shift_r, shift_nxt;
	logic [REF_DIV_W-1:0] ref_r, ref_nxt;
	logic [M_W-1:0] fb_r, fb_nxt;
	logic [2:0] post_r, post_nxt;
	logic synth_r, synth_nxt;
	logic [2:0] div4_r, div4_nxt;
	logic test_r, test_nxt;
	logic [1:0] pair_r, pair_nxt;
	logic pl, pl_rise, sclk_rise, sclk_edge, sl_fall, bypass, src_tick, fb_out;
	logic [M_W-1:0] par_m_f;
	logic [N_W-1:0] par_n_f;

	assign raw = {link.par_load, link.ser_clk, link.ser_data, link.ser_load,
		link.par_m, link.par_n};

	always_comb
	begin
		// A bit is accepted only when the second and third stages agree.
		filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			filt_r <= '0;
			prev_r <= '0;
		end
		else
		begin
			s1_r <= raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			filt_r <= filt_nxt;
			prev_r <= filt_r;
		end
	end

	assign pl = filt_r[PL];
	assign pl_rise = filt_r[PL] & ~prev_r[PL];
	assign sclk_rise = filt_r[SC] & ~prev_r[SC];
	assign sclk_edge = filt_r[SC] ^ prev_r[SC];
	assign sl_fall = ~filt_r[SL] & prev_r[SL];
	assign par_m_f = filt_r[N_W +: M_W];
	assign par_n_f = filt_r[N_W-1:0];
	assign bypass = (t_r == TEST_BYPASS);
	assign src_tick = bypass ? sclk_edge : vco_tick;
	assign fb_out = (fb_r < (m_r >> 1));

	always_comb
	begin
		m_nxt = m_r;
		n_nxt = n_r;
		t_nxt = t_r;
		shift_nxt = shift_r;
		if (!pl || pl_rise)
		begin
			m_nxt = par_m_f;
			n_nxt = par_n_f;
		end
		if (pl)
		begin
			if (sclk_rise)
				shift_nxt = {shift_r[FRAME_W-2:0], filt_r[SD]};
			if (sl_fall)
			begin
				m_nxt = shift_r[M_LSB +: M_W];
				n_nxt = shift_r[N_LSB +: N_W];
				t_nxt = shift_r[T_LSB +: T_W];
			end
		end
		if (!pl)
			t_nxt = T_RESET;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			m_r <= M_RESET;
			n_r <= N_RESET;
			t_r <= T_RESET;
			shift_r <= SHIFT_RESET;
		end
		else
		begin
			m_r <= m_nxt;
			n_r <= n_nxt;
			t_r <= t_nxt;
			shift_r <= shift_nxt;
		end
	end

	always_comb
	begin
		ref_nxt = xtal_tick ? ref_r + 1'b1 : ref_r;
		fb_nxt = fb_r;
		post_nxt = post_r;
		synth_nxt = synth_r;
		div4_nxt = div4_r;
		if (src_tick)
		begin
			if ({1'b0, fb_r} + 10'h001 >= {1'b0, m_r})
				fb_nxt = '0;
			else
				fb_nxt = fb_r + 1'b1;
			if ({1'b0, post_r} + 4'h1 >= post_ratio(n_r))
			begin
				post_nxt = '0;
				synth_nxt = ~synth_r;
				div4_nxt = div4_r + 1'b1;
			end
			else
				post_nxt = post_r + 1'b1;
		end
		case (t_r)
			// shift register out follows serial clock
			TEST_SHIFT: test_nxt = shift_r[FRAME_W-1];
			TEST_ONE: test_nxt = 1'b1;
			TEST_REF: test_nxt = ref_r[REF_DIV_W-1];
			TEST_FB: test_nxt = fb_out;
			TEST_SYNTH: test_nxt = synth_r;
			TEST_ZERO: test_nxt = 1'b0;
			TEST_BYPASS: test_nxt = fb_out;
			TEST_SYNTH4: test_nxt = div4_r[2];
			default: test_nxt = 1'b0;
		endcase
		pair_nxt = {synth_r, ~synth_r};
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ref_r <= '0;
			fb_r <= '0;
			post_r <= '0;
			synth_r <= 1'b0;
			div4_r <= '0;
			test_r <= 1'b0;
			pair_r <= 2'h1;
		end
		else
		begin
			ref_r <= ref_nxt;
			fb_r <= fb_nxt;
			post_r <= post_nxt;
			synth_r <= synth_nxt;
			div4_r <= div4_nxt;
			test_r <= test_nxt;
			pair_r <= pair_nxt;
		end
	end

	assign link.test_out = test_r;
	assign link.synth_output_pair = pair_r;
	assign cfg_m = m_r;
	assign cfg_n = n_r;
	assign cfg_t = t_r;
endmodule

// *** src/sdc_board_ctl.sv ***
// Purpose: Board controller that programs the synthesizer over its parallel and serial pins.
// Assumes: Software writes the configuration word, then a command, over AXI4-Lite.
// Notes: A command arriving while a sequence runs is dropped; status shows busy.
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module sdc_board_ctl
	import sdc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	sdc_link_if.ctl link,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum {ST_IDLE, ST_PLOW, ST_PHIGH, ST_SLO, ST_SHI, ST_LDHI, ST_LDLO} sdc_state_t;

	sdc_state_t st_r, st_nxt;
	logic [1:0] tmr_r, tmr_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [31:0] cfg_r, cfg_nxt;
	logic [FRAME_W-1:0] frame_r, frame_nxt;
	logic pl_r, pl_nxt, sc_r, sc_nxt, sd_r, sd_nxt, sl_r, sl_nxt;
	logic [M_W-1:0] pm_r, pm_nxt;
	logic [N_W-1:0] pn_r, pn_nxt;
	logic [7:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic awh_r, awh_nxt, wh_r, wh_nxt;
	logic bv_r, bv_nxt, rv_r, rv_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [2:0] tsync_r;
	logic do_wr, cmd_par, cmd_ser;

	assign do_wr = awh_r & wh_r & ~bv_r;
	assign cmd_par = do_wr && awa_r == ADDR_CMD && ws_r[0] && wd_r[CMD_PAR_BIT];
	assign cmd_ser = do_wr && awa_r == ADDR_CMD && ws_r[0] && wd_r[CMD_SER_BIT];

	always_comb
	begin
		awa_nxt = awa_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		awh_nxt = awh_r;
		wh_nxt = wh_r;
		bv_nxt = bv_r;
		br_nxt = br_r;
		rv_nxt = rv_r;
		rr_nxt = rr_r;
		rd_nxt = rd_r;
		cfg_nxt = cfg_r;
		if (s_axi_awvalid && !awh_r)
		begin
			awa_nxt = s_axi_awaddr;
			awh_nxt = 1'b1;
		end
		if (s_axi_wvalid && !wh_r)
		begin
			wd_nxt = s_axi_wdata;
			ws_nxt = s_axi_wstrb;
			wh_nxt = 1'b1;
		end
		if (do_wr)
		begin
			awh_nxt = 1'b0;
			wh_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = RESP_OKAY;
			if (awa_r == ADDR_CFG)
			begin
				for (int i = 0; i < 4; i++)
					if (ws_r[i])
						cfg_nxt[i*8 +: 8] = wd_r[i*8 +: 8];
			end
			else if (awa_r != ADDR_CMD)
				br_nxt = RESP_SLVERR;
		end
		if (bv_r && s_axi_bready)
			bv_nxt = 1'b0;
		if (s_axi_arvalid && !rv_r)
		begin
			rv_nxt = 1'b1;
			rr_nxt = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_CFG: rd_nxt = cfg_r;
				ADDR_CMD: rd_nxt = 32'h0000_0000;
				ADDR_STATUS: rd_nxt = {29'h0, tsync_r[2], pl_r, st_r != ST_IDLE};
				default:
				begin
					rd_nxt = 32'h0000_0000;
					rr_nxt = RESP_SLVERR;
				end
			endcase
		end
		else if (rv_r && s_axi_rready)
			rv_nxt = 1'b0;
	end

	always_comb
	begin
		st_nxt = st_r;
		tmr_nxt = tmr_r;
		bit_nxt = bit_r;
		frame_nxt = frame_r;
		pl_nxt = pl_r;
		sc_nxt = sc_r;
		sd_nxt = sd_r;
		sl_nxt = sl_r;
		pm_nxt = pm_r;
		pn_nxt = pn_r;
		case (st_r)
			ST_IDLE:
			begin
				tmr_nxt = '0;
				if (cmd_par)
				begin
					pm_nxt = cfg_r[M_LSB +: M_W];
					pn_nxt = cfg_r[N_LSB +: N_W];
					pl_nxt = 1'b0;
					st_nxt = ST_PLOW;
				end
				else if (cmd_ser)
				begin
					frame_nxt = cfg_r[FRAME_W-1:0];
					pl_nxt = 1'b1;
					bit_nxt = '0;
					st_nxt = ST_SLO;
				end
			end
			ST_PLOW:
			begin
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r == 2'(LOAD_PULSE_CYC - 1))
				begin
					pl_nxt = 1'b1;
					tmr_nxt = '0;
					st_nxt = ST_PHIGH;
				end
			end
			ST_PHIGH:
			begin
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r == 2'(LOAD_PULSE_CYC - 1))
					st_nxt = ST_IDLE;
			end
			ST_SLO:
			begin
				sd_nxt = frame_r[FRAME_W-1];
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r == 2'(SER_HALF_CYC - 1))
				begin
					sc_nxt = 1'b1;
					tmr_nxt = '0;
					st_nxt = ST_SHI;
				end
			end
			ST_SHI:
			begin
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r == 2'(SER_HALF_CYC - 1))
				begin
					sc_nxt = 1'b0;
					tmr_nxt = '0;
					frame_nxt = {frame_r[FRAME_W-2:0], 1'b0};
					bit_nxt = bit_r + 1'b1;
					st_nxt = (bit_r == 4'(FRAME_W - 1)) ? ST_LDHI : ST_SLO;
					if (bit_r == 4'(FRAME_W - 1))
						sl_nxt = 1'b1;
				end
			end
			ST_LDHI:
			begin
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r == 2'(LOAD_PULSE_CYC - 1))
				begin
					sl_nxt = 1'b0;
					tmr_nxt = '0;
					st_nxt = ST_LDLO;
				end
			end
			ST_LDLO:
			begin
				tmr_nxt = tmr_r + 1'b1;
				if (tmr_r == 2'(SETUP_CYC - 1))
					st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= ST_IDLE;
			tmr_r <= '0;
			bit_r <= '0;
			frame_r <= SHIFT_RESET;
			pl_r <= 1'b0;
			sc_r <= 1'b0;
			sd_r <= 1'b0;
			sl_r <= 1'b0;
			pm_r <= M_RESET;
			pn_r <= N_RESET;
			awa_r <= '0;
			wd_r <= '0;
			ws_r <= '0;
			awh_r <= 1'b0;
			wh_r <= 1'b0;
			bv_r <= 1'b0;
			br_r <= RESP_OKAY;
			rv_r <= 1'b0;
			rr_r <= RESP_OKAY;
			rd_r <= '0;
			cfg_r <= CFG_RESET;
			tsync_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			bit_r <= bit_nxt;
			frame_r <= frame_nxt;
			pl_r <= pl_nxt;
			sc_r <= sc_nxt;
			sd_r <= sd_nxt;
			sl_r <= sl_nxt;
			pm_r <= pm_nxt;
			pn_r <= pn_nxt;
			awa_r <= awa_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			awh_r <= awh_nxt;
			wh_r <= wh_nxt;
			bv_r <= bv_nxt;
			br_r <= br_nxt;
			rv_r <= rv_nxt;
			rr_r <= rr_nxt;
			rd_r <= rd_nxt;
			cfg_r <= cfg_nxt;
			tsync_r <= {tsync_r[1:0], link.test_out};
		end
	end

	assign s_axi_awready = ~awh_r;
	assign s_axi_wready = ~wh_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;
	assign s_axi_arready = ~rv_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rresp = rr_r;
	assign s_axi_rdata = rd_r;
	assign link.par_m = pm_r;
	assign link.par_n = pn_r;
	assign link.par_load = pl_r;
	assign link.ser_clk = sc_r;
	assign link.ser_data = sd_r;
	assign link.ser_load = sl_r;
endmodule

// *** testbench/sdc_link_props.sv ***
// Purpose: Concurrent checks on the link between controller and synthesizer.
// Assumes: Instantiated beside the link interface on the same mclk and rst.
// Notes: Shadows the serial frame to predict the test pin.
`timescale 1ns/1ps
module sdc_link_props
	import sdc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [M_W-1:0] par_m,
	input wire logic [N_W-1:0] par_n,
	input wire logic par_load,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_load,
	input wire logic test_out,
	input wire logic [1:0] synth_output_pair
);
	logic [FRAME_W-1:0] shd_r;
	logic [T_W-1:0] code_r;
	logic [3:0] bits_r;
	logic [3:0] calm_r;
	logic [3:0] quiet_r;

	// Calm counts cycles since par_load was last low or ser_load last fell, quiet since ser_clk moved.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			shd_r <= SHIFT_RESET;
			code_r <= T_RESET;
			bits_r <= 4'h0;
			calm_r <= 4'h0;
			quiet_r <= 4'h0;
		end
		else
		begin
			if ($rose(ser_clk))
				shd_r <= {shd_r[FRAME_W-2:0], ser_data};
			if ($fell(ser_load))
				bits_r <= 4'h0;
			else if ($rose(ser_clk))
				bits_r <= bits_r + 4'h1;
			if (!par_load)
				code_r <= T_RESET;
			else if ($fell(ser_load))
				code_r <= shd_r[FRAME_W-1 -: T_W];
			calm_r <= (!par_load || $fell(ser_load)) ? 4'h0 : calm_r + {3'h0, calm_r != 4'hF};
			quiet_r <= $changed(ser_clk) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	sequence s_clk_high;
		ser_clk [*3] ##1 !ser_clk;
	endsequence
	sequence s_xfer_pulse;
		ser_load [*3] ##1 !ser_load;
	endsequence

	a_ser_clk_width: assert property ($rose(ser_clk) |-> s_clk_high)
		else $error("serial clock high phase wrong");
	a_xfer_width: assert property ($rose(ser_load) |-> s_xfer_pulse)
		else $error("transfer strobe width wrong");
	a_ser_needs_load: assert property (ser_clk || ser_load |-> par_load)
		else $error("serial activity with parallel strobe low");
	a_frame_count: assert property ($rose(ser_load) |-> bits_r == 4'hE)
		else $error("frame bit count wrong");
	a_par_setup: assert property ($rose(par_load) |-> $stable(par_m) && $stable(par_n))
		else $error("parallel values moved at strobe rise");
	a_pair_compl: assert property (synth_output_pair[1] != synth_output_pair[0])
		else $error("output pair not complementary");
	a_test_one: assert property (calm_r == 4'hF && code_r == TEST_ONE |-> test_out)
		else $error("test pin not one");
	a_test_zero: assert property (calm_r == 4'hF && code_r == TEST_ZERO |-> !test_out)
		else $error("test pin not zero");
	a_shift_out: assert property (calm_r == 4'hF && quiet_r == 4'hF && code_r == TEST_SHIFT
		|-> test_out == shd_r[FRAME_W-1])
		else $error("test pin not shift output");
	a_bypass_hold: assert property (calm_r == 4'hF && quiet_r == 4'hF
		&& code_r == TEST_BYPASS |=> $stable(synth_output_pair))
		else $error("bypass output moved without serial clock");
	a_bypass_src: assert property (calm_r == 4'hF && code_r == TEST_BYPASS
		&& $changed(synth_output_pair) |-> quiet_r < 4'h8)
		else $error("bypass output changed far from a serial clock edge");
endmodule

// *** testbench/testbench.sv ***
// Purpose: Programs the synthesizer through the controller and checks the result.
// Assumes: Both ends joined by one link interface on a 50 MHz mclk.
// Notes: Read results are checked by a monitor against a queue of notes.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
	$display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module testbench;
	import sdc_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic vco_tick = 1'b0;
	logic xtal_tick = 1'b0;
	logic [7:0] aw_a = 8'h00;
	logic [7:0] ar_a = 8'h00;
	logic [31:0] w_d = 32'h0;
	logic [3:0] w_s = 4'hF;
	logic aw_v = 1'b0;
	logic w_v = 1'b0;
	logic b_r = 1'b0;
	logic ar_v = 1'b0;
	logic r_r = 1'b0;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	logic [1:0] b_s, r_s;
	logic [31:0] r_d;
	logic [M_W-1:0] cfg_m;
	logic [N_W-1:0] cfg_n;
	logic [T_W-1:0] cfg_t;
	logic [31:0] seed = 32'h48;
	logic [34:0] notes[$];
	logic [34:0] note;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;

	sdc_link_if i_sdc_link_if();
	sdc_synth_dev i_sdc_synth_dev(.mclk(mclk), .rst(rst), .link(i_sdc_link_if),
		.vco_tick(vco_tick), .xtal_tick(xtal_tick), .cfg_m(cfg_m), .cfg_n(cfg_n),
		.cfg_t(cfg_t));
	sdc_board_ctl i_sdc_board_ctl(.mclk(mclk), .rst(rst), .link(i_sdc_link_if),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
		.s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
		.s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
		.s_axi_rdata(r_d), .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
	sdc_link_props i_props(.mclk(mclk), .rst(rst), .par_m(i_sdc_link_if.par_m),
		.par_n(i_sdc_link_if.par_n), .par_load(i_sdc_link_if.par_load),
		.ser_clk(i_sdc_link_if.ser_clk), .ser_data(i_sdc_link_if.ser_data),
		.ser_load(i_sdc_link_if.ser_load), .test_out(i_sdc_link_if.test_out),
		.synth_output_pair(i_sdc_link_if.synth_output_pair));

	always #10 mclk = ~mclk;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic finish_test();
		$display("Counts: %0d comparisons, %0d failures", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// A VCO tick every second cycle makes each output half period last twice the post-divider ratio (2 << N) in cycles.
	always @(posedge mclk)
	begin
		vco_tick <= ~vco_tick;
		xtal_tick <= (cycles % 3 == 0);
		cycles = cycles + 1;
		if (cycles == 30000)
		begin
			failures++;
			finish_test();
		end
	end

	always @(posedge mclk)
	begin
		if (r_v && r_r)
		begin
			note = notes.pop_front();
			if (note[34])
				`CHK({r_s, r_d}, note[33:0])
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] s);
		@(posedge mclk);
		aw_a <= a;
		aw_v <= 1'b1;
		w_d <= d;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (aw_rdy)
				aw_v <= 1'b0;
			if (w_rdy)
				w_v <= 1'b0;
		end
		while (!b_v);
		s = b_s;
		b_r <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic chk, input logic [33:0] e,
		output logic [31:0] d);
		notes.push_back({chk, e});
		@(posedge mclk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (ar_rdy)
				ar_v <= 1'b0;
		end
		while (!r_v);
		d = r_d;
		r_r <= 1'b0;
	endtask

	task automatic wait_tog(output int c);
		logic p;
		p = i_sdc_link_if.synth_output_pair[1];
		for (c = 1; c < 100; c++)
		begin
			@(posedge mclk);
			if (i_sdc_link_if.synth_output_pair[1] !== p)
				break;
		end
	endtask

	task automatic prog(input logic [1:0] cmd, input logic [13:0] f);
		logic [1:0] s;
		logic [31:0] d;
		logic [2:0] t;
		int i;
		t = cmd[0] ? 3'h0 : f[13:11];
		wr(ADDR_CFG, {18'h0, f}, s);
		`CHK(s, RESP_OKAY)
		wr(ADDR_CMD, {30'h0, cmd}, s);
		`CHK(s, RESP_OKAY)
		if (cmd == 2'h2)
		begin
			// A parallel command sent while the frame runs must be dropped.
			wr(ADDR_CMD, 32'h0000_0001, s);
			`CHK(s, RESP_OKAY)
		end
		d = 32'h1;
		for (i = 0; i < 100 && d[0]; i++)
			rd(ADDR_STATUS, 1'b0, 34'h0, d);
		`CHK(d[1:0], 2'h2)
		for (i = 0; i < 30 && {cfg_t, cfg_n, cfg_m} !== {t, f[10:0]}; i++)
			@(posedge mclk);
		`CHK(cfg_m, f[M_LSB +: M_W])
		`CHK(cfg_n, f[N_LSB +: N_W])
		`CHK(cfg_t, t)
		if (t != TEST_BYPASS)
		begin
			repeat (3)
				wait_tog(i);
			`CHK(i, 2 << f[10:9])
		end
		else
			repeat (20) @(posedge mclk);
		$display("Test done: command %0h frame %h", cmd, f);
	endtask

	initial
	begin
		logic [31:0] d;
		logic [1:0] s;
		int k;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rd(ADDR_CFG, 1'b1, {RESP_OKAY, CFG_RESET}, d);
		rd(8'h0C, 1'b1, {RESP_SLVERR, 32'h0}, d);
		rd(ADDR_CMD, 1'b1, {RESP_OKAY, 32'h0}, d);
		wr(8'h0C, 32'hFFFF_FFFF, s);
		`CHK(s, RESP_SLVERR)
		w_s <= 4'h1;
		wr(ADDR_CFG, 32'hFFFF_FFFF, s);
		`CHK(s, RESP_OKAY)
		w_s <= 4'hF;
		rd(ADDR_CFG, 1'b1, {RESP_OKAY, 32'h0000_00FF}, d);
		$display("Test done: reset and unmapped access");
		d = xs();
		prog(2'h1, d[13:0]);
		for (k = 0; k < 8; k++)
		begin
			d = xs();
			prog(2'h2, {k[2:0], d[10:0]});
		end
		d = xs();
		prog(2'h3, d[13:0]);
		finish_test();
	end
endmodule
